// File: core/l2ca_pkg.sv
// Operation
// (RULE1) Four 64-bit chunk data registers, read/write
// (RULE2) Chunk 3 doubles as update signature
// (RULE3) Address bits 31:3 only, rest zero
// (RULE4) ECC byte written, refreshed from cache; the code refreshes it only on read commands
// (RULE5) Control holds command, captures lookup response
// (RULE6) Decode fixed five-bit command codes
// (RULE7) Tag writes: prefix plus coherence state
// (RULE8) Coherence states M11 E10 S01 I00
// (RULE9) Way encoded in two binary bits
// (RULE10) Trigger write starts programmed command
// (RULE11) Software writes zero to trigger only
// (RULE12) Busy bit 0 high while in progress
// (RULE13) Load, trigger, poll busy, then read
// (RULE14) Writes ignored while busy
package l2ca_pkg;
  // Printed register indices; byte address is four times index
  localparam logic [11:0] IDX_D0    = 12'h088;
  localparam logic [11:0] IDX_D1    = 12'h089;
  localparam logic [11:0] IDX_D2    = 12'h08A;
  localparam logic [11:0] IDX_D3    = 12'h08B;
  localparam logic [11:0] IDX_ADDR  = 12'h116;
  localparam logic [11:0] IDX_ECC   = 12'h118;
  localparam logic [11:0] IDX_CTL   = 12'h119;
  localparam logic [11:0] IDX_TRIG  = 12'h11A;
  localparam logic [11:0] IDX_BUSY  = 12'h11B;
  localparam logic [11:0] IDX_STAGE = 12'h120;
  localparam logic [11:0] IDX_HOLD  = 12'h121;
  localparam logic [11:0] A_D0      = IDX_D0 << 2;
  localparam logic [11:0] A_D1      = IDX_D1 << 2;
  localparam logic [11:0] A_D2      = IDX_D2 << 2;
  localparam logic [11:0] A_D3      = IDX_D3 << 2;
  localparam logic [11:0] A_ADDR    = IDX_ADDR << 2;
  localparam logic [11:0] A_ECC     = IDX_ECC << 2;
  localparam logic [11:0] A_CTL     = IDX_CTL << 2;
  localparam logic [11:0] A_TRIG    = IDX_TRIG << 2;
  localparam logic [11:0] A_BUSY    = IDX_BUSY << 2;
  localparam logic [11:0] A_STAGE   = IDX_STAGE << 2;
  localparam logic [11:0] A_HOLD    = IDX_HOLD << 2;
  // Control field positions
  localparam int CMD_LSB  = 0;
  localparam int STO_LSB  = 5;
  localparam int WTO_LSB  = 8;
  localparam int WFR_LSB  = 10;
  localparam int SFR_LSB  = 12;
  localparam int HIT_BIT  = 16;
  localparam int UECC_BIT = 18;
  localparam int PND_BIT  = 21;
  localparam int ADDR_LSB = 3;
  // Commands
  localparam logic [4:0] C_DATA_READ_LRU_UPDATE = 5'h0C;
  localparam logic [4:0] C_TAG_READ_DATA_READ   = 5'h0E;
  localparam logic [4:0] C_TAG_INQUIRE          = 5'h0F;
  localparam logic [4:0] C_CACHE_CTRL_REG_READ  = 5'h02;
  localparam logic [4:0] C_CACHE_CTRL_REG_WRITE = 5'h03;
  localparam logic [2:0] P_TAG_WRITE_DATA_READ  = 3'h2;
  localparam logic [2:0] P_TAG_WRITE_DATA_WRITE = 3'h7;
  localparam logic [2:0] P_TAG_WRITE_ONLY       = 3'h4;
  // Coherence states
  localparam logic [1:0] MESI_M = 2'h3;
  localparam logic [1:0] MESI_E = 2'h2;
  localparam logic [1:0] MESI_S = 2'h1;
  localparam logic [1:0] MESI_I = 2'h0;
  localparam logic [63:0] RST_CHUNK = 64'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_FIN  = 2'h3
  } l2ca_state_t;
endpackage : l2ca_pkg

// File: core/l2ca_core.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module l2ca_core (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              cache_req_valid,
  output logic      [4:0]   cache_req_cmd,
  output logic      [28:0]  cache_req_addr,
  output logic      [255:0] cache_req_data,
  output logic      [7:0]   cache_req_ecc,
  output logic      [1:0]   cache_req_state,
  output logic      [1:0]   cache_req_way,
  output logic              cache_req_user_ecc,
  input  wire logic         cache_resp_valid,
  input  wire logic         cache_resp_hit,
  input  wire logic [1:0]   cache_resp_state,
  input  wire logic [1:0]   cache_resp_way,
  input  wire logic [255:0] cache_resp_data,
  input  wire logic [7:0]   cache_resp_ecc
);
  typedef struct packed {
    l2ca_pkg::l2ca_state_t st;
    logic [3:0][63:0]      d;
    logic [28:0]           addr;
    logic [7:0]            ecc;
    logic [4:0]            cmd;
    logic [1:0]            st_to;
    logic [1:0]            way_to;
    logic [1:0]            st_from;
    logic [1:0]            way_from;
    logic                  hit;
    logic                  uecc;
    logic                  pn_dis;
    logic [31:0]           stage;
    logic [31:0]           hold;
    logic [31:0]           rdat;
    logic                  err;
  } l2ca_regs_t;

  l2ca_regs_t q_ff;
  l2ca_regs_t nxt_q;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        idle;
  logic        is_chunk;
  logic [1:0]  ci;
  logic        cmd_tagw;
  logic        cmd_ok;
  logic        cmd_rd;
  logic [31:0] rdata;
  logic        mapped;
  logic [31:0] ctl_word;

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign rd       = acc & ~pwrite;
  assign idle     = q_ff.st == l2ca_pkg::ST_IDLE;
  assign is_chunk = paddr[11:4] == l2ca_pkg::A_D0[11:4]; // [RULE1] [RULE2]
  assign ci       = paddr[3:2];

  // Command decode
  assign cmd_tagw = (q_ff.cmd[4:2] == l2ca_pkg::P_TAG_WRITE_DATA_READ)
                  | (q_ff.cmd[4:2] == l2ca_pkg::P_TAG_WRITE_DATA_WRITE)
                  | (q_ff.cmd[4:2] == l2ca_pkg::P_TAG_WRITE_ONLY); // [RULE7]
  assign cmd_ok   = cmd_tagw
                  | (q_ff.cmd == l2ca_pkg::C_DATA_READ_LRU_UPDATE)
                  | (q_ff.cmd == l2ca_pkg::C_TAG_READ_DATA_READ)
                  | (q_ff.cmd == l2ca_pkg::C_TAG_INQUIRE)
                  | (q_ff.cmd == l2ca_pkg::C_CACHE_CTRL_REG_READ)
                  | (q_ff.cmd == l2ca_pkg::C_CACHE_CTRL_REG_WRITE); // [RULE6]
  assign cmd_rd   = (q_ff.cmd == l2ca_pkg::C_DATA_READ_LRU_UPDATE)
                  | (q_ff.cmd == l2ca_pkg::C_TAG_READ_DATA_READ)
                  | (q_ff.cmd == l2ca_pkg::C_CACHE_CTRL_REG_READ)
                  | (q_ff.cmd[4:2] == l2ca_pkg::P_TAG_WRITE_DATA_READ); // [RULE6]

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[l2ca_pkg::CMD_LSB +: 5] = q_ff.cmd;
    ctl_word[l2ca_pkg::STO_LSB +: 2] = q_ff.st_to; // [RULE8]
    ctl_word[l2ca_pkg::WTO_LSB +: 2] = q_ff.way_to; // [RULE9]
    ctl_word[l2ca_pkg::WFR_LSB +: 2] = q_ff.way_from;
    ctl_word[l2ca_pkg::SFR_LSB +: 2] = q_ff.st_from;
    ctl_word[l2ca_pkg::HIT_BIT]      = q_ff.hit; // [RULE5]
    ctl_word[l2ca_pkg::UECC_BIT]     = q_ff.uecc;
    ctl_word[l2ca_pkg::PND_BIT]      = q_ff.pn_dis;
  end

  // Read mux; unmapped reads give zero and an error
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    if (is_chunk) begin
      rdata = q_ff.d[ci][31:0];
    end else begin
      case (paddr)
        l2ca_pkg::A_ADDR:  rdata = {q_ff.addr, 3'h0}; // [RULE3]
        l2ca_pkg::A_ECC:   rdata = {24'h00_0000, q_ff.ecc}; // [RULE4]
        l2ca_pkg::A_CTL:   rdata = ctl_word;
        l2ca_pkg::A_TRIG:  rdata = 32'h0000_0000;
        l2ca_pkg::A_BUSY:  rdata = {31'h0000_0000, ~idle}; // [RULE12]
        l2ca_pkg::A_STAGE: rdata = q_ff.stage;
        l2ca_pkg::A_HOLD:  rdata = q_ff.hold;
        default:           mapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    nxt_q = q_ff;
    if (psel && !penable) begin
      nxt_q.rdat = rdata;
      nxt_q.err  = ~mapped;
    end
    if (rd && is_chunk) begin
      nxt_q.hold = q_ff.d[ci][63:32];
    end
    if (wr && idle) begin // [RULE14]
      if (is_chunk) begin
        nxt_q.d[ci] = {q_ff.stage, pwdata}; // [RULE1] [RULE2]
      end
      case (paddr)
        l2ca_pkg::A_ADDR:  nxt_q.addr = pwdata[31:l2ca_pkg::ADDR_LSB]; // [RULE3]
        l2ca_pkg::A_ECC:   nxt_q.ecc = pwdata[7:0]; // [RULE4]
        l2ca_pkg::A_CTL: begin // [RULE5]
          nxt_q.cmd    = pwdata[l2ca_pkg::CMD_LSB +: 5];
          nxt_q.st_to  = pwdata[l2ca_pkg::STO_LSB +: 2];
          nxt_q.way_to = pwdata[l2ca_pkg::WTO_LSB +: 2];
          nxt_q.uecc   = pwdata[l2ca_pkg::UECC_BIT];
          nxt_q.pn_dis = pwdata[l2ca_pkg::PND_BIT];
        end
        l2ca_pkg::A_STAGE: nxt_q.stage = pwdata;
        l2ca_pkg::A_TRIG: begin // [RULE10]
          nxt_q.st = cmd_ok ? l2ca_pkg::ST_WAIT : l2ca_pkg::ST_FIN;
        end
        default: ;
      endcase
    end
    case (q_ff.st)
      l2ca_pkg::ST_WAIT: begin
        if (cache_resp_valid) begin // [RULE5] [RULE12]
          nxt_q.st       = l2ca_pkg::ST_IDLE;
          nxt_q.hit      = cache_resp_hit;
          nxt_q.st_from  = cache_resp_state; // [RULE8]
          nxt_q.way_from = cache_resp_way; // [RULE9]
          if (cmd_rd) begin
            nxt_q.d   = cache_resp_data;
            nxt_q.ecc = cache_resp_ecc; // [RULE4]
          end
        end
      end
      l2ca_pkg::ST_FIN: nxt_q.st = l2ca_pkg::ST_IDLE;
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prdata             = q_ff.rdat;
  assign pready             = 1'b1;
  assign pslverr            = acc & q_ff.err;
  assign cache_req_valid    = q_ff.st == l2ca_pkg::ST_WAIT;
  assign cache_req_cmd      = q_ff.cmd;
  assign cache_req_addr     = q_ff.addr;
  assign cache_req_data     = q_ff.d;
  assign cache_req_ecc      = q_ff.ecc;
  assign cache_req_state    = cmd_tagw ? q_ff.cmd[1:0] : q_ff.st_to; // [RULE7]
  assign cache_req_way      = q_ff.way_to; // [RULE9]
  assign cache_req_user_ecc = q_ff.uecc;

  property p_busy_read;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == l2ca_pkg::A_BUSY
      |=> prdata[0] == $past(!idle) && prdata[31:1] == 31'h0000_0000;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read wrong"); // [RULE12]

  property p_trig_start;
    @(posedge pclk) disable iff (!presetn)
    wr && idle && paddr == l2ca_pkg::A_TRIG && cmd_ok |=> cache_req_valid;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start"); // [RULE10]

  property p_bad_cmd;
    @(posedge pclk) disable iff (!presetn)
    wr && idle && paddr == l2ca_pkg::A_TRIG && !cmd_ok
      |=> !cache_req_valid && !idle ##1 idle;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not dropped"); // [RULE6]

  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
    !idle |=> $stable(q_ff.addr) && $stable(q_ff.cmd) && $stable(q_ff.stage);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write taken while busy"); // [RULE14]

  property p_addr_low;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == l2ca_pkg::A_ADDR |=> prdata[2:0] == 3'h0;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("address low bits set"); // [RULE3]

  property p_resp_cap;
    @(posedge pclk) disable iff (!presetn)
    cache_req_valid && cache_resp_valid
      |=> idle && q_ff.hit == $past(cache_resp_hit) && q_ff.way_from == $past(cache_resp_way)
          && q_ff.st_from == $past(cache_resp_state);
  endproperty
  a_resp_cap: assert property (p_resp_cap) else $error("response not captured"); // [RULE5]

  property p_ecc_cap;
    @(posedge pclk) disable iff (!presetn)
    cache_req_valid && cache_resp_valid && cmd_rd |=> q_ff.ecc == $past(cache_resp_ecc);
  endproperty
  a_ecc_cap: assert property (p_ecc_cap) else $error("ecc not refreshed"); // [RULE4]

  property p_chunk_wr;
    @(posedge pclk) disable iff (!presetn)
    wr && idle && is_chunk |=> q_ff.d[$past(ci)] == {$past(q_ff.stage), $past(pwdata)};
  endproperty
  a_chunk_wr: assert property (p_chunk_wr) else $error("chunk write lost"); // [RULE1]

  property p_tagw_state;
    @(posedge pclk) disable iff (!presetn)
    cache_req_valid && (cache_req_cmd[4:2] == l2ca_pkg::P_TAG_WRITE_DATA_READ
      || cache_req_cmd[4:2] == l2ca_pkg::P_TAG_WRITE_DATA_WRITE
      || cache_req_cmd[4:2] == l2ca_pkg::P_TAG_WRITE_ONLY)
      |-> cache_req_state == cache_req_cmd[1:0];
  endproperty
  a_tagw_state: assert property (p_tagw_state) else $error("tag write state wrong"); // [RULE7]

  property p_req_hold;
    @(posedge pclk) disable iff (!presetn)
    cache_req_valid && !cache_resp_valid |=> cache_req_valid && $stable(cache_req_cmd);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early"); // [RULE12]

  c_trigger: cover property (@(posedge pclk) disable iff (!presetn)
    wr && idle && paddr == l2ca_pkg::A_TRIG);
  c_read_done: cover property (@(posedge pclk) disable iff (!presetn)
    cache_req_valid && cache_resp_valid && cmd_rd);
  c_busy_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr && !idle && paddr == l2ca_pkg::A_ADDR);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) acc && pslverr);
endmodule : l2ca_core

// File: verification/l2ca_cache_model.sv
`timescale 1ns/1ps
module l2ca_cache_model (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         req_valid,
  input  wire logic         slow,
  output logic              resp_valid,
  output logic              resp_hit,
  output logic      [1:0]   resp_state,
  output logic      [1:0]   resp_way,
  output logic      [255:0] resp_data,
  output logic      [7:0]   resp_ecc
);
  localparam logic [63:0] CHUNK = 64'hFEDC_BA98_7654_3210;
  logic [3:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_ff <= 4'h0;
    else if (!req_valid || resp_valid) cnt_ff <= 4'h0;
    else cnt_ff <= cnt_ff + 4'h1;
  end
  assign resp_valid = req_valid && (cnt_ff == (slow ? 4'hA : 4'h1));
  // Outside the answer cycle the lines show the inverse
  assign resp_hit   = resp_valid;
  assign resp_state = resp_valid ? l2ca_pkg::MESI_E : ~l2ca_pkg::MESI_E;
  assign resp_way   = resp_valid ? 2'h3 : 2'h0;
  assign resp_data  = resp_valid ? {4{CHUNK}} : ~{4{CHUNK}};
  assign resp_ecc   = resp_valid ? 8'h5A : 8'hA5;
endmodule : l2ca_cache_model

// File: verification/l2_config_access_port_tb.sv
`timescale 1ns/1ps
module l2_config_access_port_tb;
  localparam logic [63:0] CHUNK = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] PAT   = 64'h0123_4567_89AB_CDEF;
  localparam logic [4:0] CMDS [9] = '{l2ca_pkg::C_DATA_READ_LRU_UPDATE,
    l2ca_pkg::C_TAG_READ_DATA_READ, l2ca_pkg::C_TAG_INQUIRE, l2ca_pkg::C_CACHE_CTRL_REG_READ,
    l2ca_pkg::C_CACHE_CTRL_REG_WRITE, {l2ca_pkg::P_TAG_WRITE_DATA_READ, l2ca_pkg::MESI_M},
    {l2ca_pkg::P_TAG_WRITE_DATA_WRITE, l2ca_pkg::MESI_E},
    {l2ca_pkg::P_TAG_WRITE_ONLY, l2ca_pkg::MESI_S},
    {l2ca_pkg::P_TAG_WRITE_ONLY, l2ca_pkg::MESI_I}};
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic         req_valid, req_uecc, rv, rhit;
  logic [4:0]   req_cmd;
  logic [28:0]  req_addr;
  logic [255:0] req_data, rdat;
  logic [7:0]   req_ecc, recc;
  logic [1:0]   req_state, req_way, rstate, rway;
  int           mismatches, checks;
  l2ca_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cache_req_valid(req_valid), .cache_req_cmd(req_cmd),
    .cache_req_addr(req_addr), .cache_req_data(req_data), .cache_req_ecc(req_ecc),
    .cache_req_state(req_state), .cache_req_way(req_way), .cache_req_user_ecc(req_uecc),
    .cache_resp_valid(rv), .cache_resp_hit(rhit), .cache_resp_state(rstate),
    .cache_resp_way(rway), .cache_resp_data(rdat), .cache_resp_ecc(recc));
  l2ca_cache_model cache (.pclk(pclk), .presetn(presetn), .req_valid(req_valid), .slow(slow),
    .resp_valid(rv), .resp_hit(rhit), .resp_state(rstate), .resp_way(rway),
    .resp_data(rdat), .resp_ecc(recc));
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
  endtask : rd
  task automatic w64(input logic [11:0] a, input logic [63:0] v);
    wr(l2ca_pkg::A_STAGE, v[63:32]);
    wr(a, v[31:0]);
  endtask : w64
  task automatic r64(input logic [11:0] a, output logic [63:0] v);
    rd(a, v[31:0]);
    rd(l2ca_pkg::A_HOLD, v[63:32]);
  endtask : r64
  task automatic wait_idle();
    logic [31:0] r;
    for (int i = 0; i < 40; i++) begin
      rd(l2ca_pkg::A_BUSY, r);
      if (r[0] === 1'b0) return;
    end
    mismatches++;
    report_and_stop();
  endtask : wait_idle
  task automatic s_regs();
    logic [63:0] v;
    logic [31:0] r;
    logic        e;
    rd(l2ca_pkg::A_BUSY, r);
    chk("busy reset", 64'(r), 64'h0);
    for (int i = 0; i < 4; i++) begin
      w64(l2ca_pkg::A_D0 + 12'(4 * i), 64'h0101_0101_0101_0101 * 64'(i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      r64(l2ca_pkg::A_D0 + 12'(4 * i), v);
      chk("chunk", v, 64'h0101_0101_0101_0101 * 64'(i + 1));
    end
    wr(l2ca_pkg::A_ADDR, 32'hFFFF_FFF8);
    rd(l2ca_pkg::A_ADDR, r);
    chk("addr", 64'(r), 64'hFFFF_FFF8);
    chk("req addr", 64'(req_addr), 64'h1FFF_FFFF);
    wr(l2ca_pkg::A_ECC, 32'h0000_003C);
    rd(l2ca_pkg::A_ECC, r);
    chk("ecc", 64'(r), 64'h3C);
    apb(12'h004, 1'b0, 32'h0, r, e);
    chk("unmapped err", 64'(e), 64'h1);
  endtask : s_regs
  task automatic s_busy();
    logic [31:0] r;
    slow <= 1'b1;
    wr(l2ca_pkg::A_D0, 32'h0000_00AA);
    wr(l2ca_pkg::A_CTL, {27'h0, l2ca_pkg::C_TAG_INQUIRE});
    wr(l2ca_pkg::A_TRIG, 32'h0);
    wr(l2ca_pkg::A_CTL, {27'h0, l2ca_pkg::C_DATA_READ_LRU_UPDATE});
    wr(l2ca_pkg::A_ADDR, 32'h0000_0008);
    wr(l2ca_pkg::A_D0, 32'h0000_0055);
    wait_idle();
    rd(l2ca_pkg::A_CTL, r);
    chk("ctl while busy", 64'(r[4:0]), 64'(l2ca_pkg::C_TAG_INQUIRE));
    rd(l2ca_pkg::A_ADDR, r);
    chk("addr while busy", 64'(r), 64'hFFFF_FFF8);
    rd(l2ca_pkg::A_D0, r);
    chk("chunk while busy", 64'(r), 64'hAA);
  endtask : s_busy
  task automatic s_bad();
    logic [31:0] r;
    wr(l2ca_pkg::A_CTL, 32'h0000_0001);
    wr(l2ca_pkg::A_TRIG, 32'h0);
    rd(l2ca_pkg::A_BUSY, r);
    chk("bad cmd busy", 64'(r[0]), 64'h0);
    chk("bad cmd req", 64'(req_valid), 64'h0);
  endtask : s_bad
  task automatic s_cmd(input logic [4:0] c);
    logic [63:0] v;
    logic [31:0] r;
    logic        tw, is_rd;
    tw = c[4:2] inside {l2ca_pkg::P_TAG_WRITE_DATA_READ, l2ca_pkg::P_TAG_WRITE_DATA_WRITE,
                        l2ca_pkg::P_TAG_WRITE_ONLY};
    is_rd = (c inside {5'h0C, 5'h0E, 5'h02}) || (c[4:2] == 3'h2);
    w64(l2ca_pkg::A_D0, PAT);
    wr(l2ca_pkg::A_ECC, 32'h0000_00C3);
    wr(l2ca_pkg::A_CTL, {10'h0, 1'b1, 2'h0, 1'b1, 8'h0, 2'h2, 1'b0, 2'h1, c});
    wr(l2ca_pkg::A_TRIG, 32'h0);
    chk("req data", req_data[63:0], PAT);
    chk("req ecc", 64'(req_ecc), 64'hC3);
    chk("req uecc", 64'(req_uecc), 64'h1);
    rd(l2ca_pkg::A_BUSY, r);
    chk("busy", 64'(r[0]), 64'h1);
    chk("req cmd", 64'(req_cmd), 64'(c));
    chk("req state", 64'(req_state), tw ? 64'(c[1:0]) : 64'h1);
    chk("req way", 64'(req_way), 64'h2);
    wait_idle();
    rd(l2ca_pkg::A_CTL, r);
    chk("response", 64'({r[16], r[13:12], r[11:10]}), 64'h1B);
    chk("ctl flags", 64'({r[21], r[18]}), 64'h3);
    r64(l2ca_pkg::A_D0, v);
    chk("read data", v, is_rd ? CHUNK : PAT);
    rd(l2ca_pkg::A_ECC, r);
    chk("read ecc", 64'(r), is_rd ? 64'h5A : 64'hC3);
  endtask : s_cmd
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_busy();
    s_bad();
    for (int i = 0; i < 9; i++) begin
      slow <= i[0];
      s_cmd(CMDS[i]);
    end
    report_and_stop();
  end
endmodule : l2_config_access_port_tb
